// [inc/arxf_pkg.sv]
// Purpose: Shared constants for the ASCII receive message framer.
// Assumes: 100 MHz ref_clk, classic Wishbone register access.
// Notes: Offsets are byte addresses of 32-bit words.
package arxf_pkg;
  localparam int unsigned CLK_HZ = 100000000;
  localparam int unsigned TICK_MS = 1;
  localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned BUF_DEPTH = 255;
  localparam int unsigned TERM_MAX = 12;
  localparam int unsigned PKT_MAX = 200;
  // Termination type bits
  localparam int unsigned TT_CHAR = 0;
  localparam int unsigned TT_MSGTO = 1;
  localparam int unsigned TT_GAP = 2;
  localparam int unsigned TT_LEN = 3;
  // Base setting meaning disabled
  localparam logic [15:0] BASE_OFF = 16'hFFFF;
  // Register byte offsets
  localparam logic [7:0] A_RXBASE = 8'h00;
  localparam logic [7:0] A_TXBASE = 8'h04;
  localparam logic [7:0] A_TTYPE = 8'h08;
  localparam logic [7:0] A_TCOUNT = 8'h0C;
  localparam logic [7:0] A_PKTLEN = 8'h10;
  localparam logic [7:0] A_MSGTO = 8'h14;
  localparam logic [7:0] A_GAPTO = 8'h18;
  localparam logic [7:0] A_STATUS = 8'h1C;
  localparam logic [7:0] A_TCHAR0 = 8'h40;
  localparam logic [7:0] A_TCHAR_END = 8'h70;
  // Reset values
  localparam logic [15:0] RST_BASE = 16'hFFFF;
  localparam logic [7:0] RST_TTYPE = 8'h00;
  // Framer states
  typedef enum logic [2:0] {
    ST_LISTEN = 3'b001,
    ST_RECV = 3'b010,
    ST_SEND = 3'b100
  } arxf_state_e;
endpackage

// [core/arxf_ms_timer.sv]
// Purpose: Millisecond down counter that flags expiry.
// Assumes: tick is a one-cycle pulse once per millisecond.
// Notes: A limit of zero expires at the next tick after start.
module arxf_ms_timer #(
  parameter int W = 16
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic tick,
  input wire logic start,
  input wire logic stop,
  input wire logic [W-1:0] limit,
  output logic expired
);
  logic [W-1:0] count_q;
  logic run_q;

  // Restart wins over tick so a late character always gets a full period
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst || stop)
    begin
      run_q <= 1'b0;
      count_q <= '0;
    end
    else if (start)
    begin
      run_q <= 1'b1;
      count_q <= limit;
    end
    else if (run_q && tick)
    begin
      if (count_q == '0)
        run_q <= 1'b0;
      else
        count_q <= count_q - 1'b1;
    end
  end

  // Stop is left out: it comes back from the close logic, which reads
  // expired, and would otherwise form a combinational loop
  assign expired = run_q && tick && (count_q == '0) && !start;
endmodule

// [core/arxf_tick_gen.sv]
// Purpose: One-millisecond tick from the system clock.
// Assumes: Period in cycles set by parameter.
// Notes: Free running; timers see up to one tick of jitter at start.
module arxf_tick_gen #(
  parameter int unsigned PERIOD = arxf_pkg::TICK_CYCLES
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  output logic tick
);
  localparam int CW = $clog2(PERIOD);
  localparam logic [CW-1:0] LAST = CW'(PERIOD - 1);
  logic [CW-1:0] div_q;

  // Divider wraps at the period end
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst || div_q == LAST)
      div_q <= '0;
    else
      div_q <= div_q + 1'b1;
  end

  assign tick = (div_q == LAST);
endmodule

// [core/arxf_framer.sv]
// Purpose: Receive framer collecting characters into blocks for the database.
// Assumes: Characters arrive as one-cycle strobes on ref_clk; drain stalls.
// Notes: Registers over classic Wishbone; unmapped reads return zero.
module arxf_framer #(
  parameter int unsigned DEPTH = arxf_pkg::BUF_DEPTH,
  parameter int unsigned TICK_PERIOD = arxf_pkg::TICK_CYCLES
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic rxValid,
  input wire logic [7:0] rxChar,
  output logic rxDropped,
  output logic dbValid,
  output logic [7:0] dbData,
  output logic dbLast,
  output logic [15:0] dbBase,
  input wire logic dbReady,
  output logic rxEnable,
  output logic txEnable,
  output logic [15:0] transmitSourceBase
);
  localparam int PW = $clog2(DEPTH + 1);
  localparam logic [PW-1:0] FULL = PW'(DEPTH);

  // Configuration registers
  logic [15:0] receiveStoreBase_q;
  logic [15:0] transmitSourceBase_q;
  logic [7:0] termType_q;
  logic [3:0] terminatorCount_q;
  logic [7:0] packetLength_q;
  logic [15:0] msgTimeout_q;
  logic [15:0] gapTimeout_q;
  logic [7:0] terminatorChars_q [arxf_pkg::TERM_MAX];

  // Buffer and state
  logic [7:0] mem_q [DEPTH];
  logic [PW-1:0] fill_q;
  logic [PW-1:0] sendLen_q;
  logic [PW-1:0] rdPtr_q;
  logic [15:0] msgCount_q;
  logic [15:0] charCount_q;
  logic [7:0] dbData_q;
  arxf_pkg::arxf_state_e state_q;

  logic wbReq;
  logic tick;
  logic msgExpired;
  logic gapExpired;
  logic accept;
  logic isTerm;
  logic endBlock;
  logic streamMode;
  logic [PW-1:0] newFill;
  logic [3:0] wordIdx;
  logic drainBeat;
  logic [PW-1:0] nextRd;

  assign wbReq = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wordIdx = 4'((wb_adr_i - arxf_pkg::A_TCHAR0) >> 2);

  // Modes from the base settings and the termination type
  assign rxEnable = (receiveStoreBase_q != arxf_pkg::BASE_OFF);
  assign txEnable = (transmitSourceBase_q != arxf_pkg::BASE_OFF);
  assign transmitSourceBase = transmitSourceBase_q;
  assign dbBase = receiveStoreBase_q;
  assign streamMode = (termType_q[3:0] == 4'h0);

  // Wishbone ack: one cycle per request, dropped the next cycle
  // Gated by its own last value, so a held request is answered every other cycle
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= wbReq;
  end

  // Register writes; low byte lane carries narrow fields
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      receiveStoreBase_q <= arxf_pkg::RST_BASE;
      transmitSourceBase_q <= arxf_pkg::RST_BASE;
      termType_q <= arxf_pkg::RST_TTYPE;
      terminatorCount_q <= '0;
      packetLength_q <= '0;
      msgTimeout_q <= '0;
      gapTimeout_q <= '0;
      for (int i = 0; i < arxf_pkg::TERM_MAX; i++)
        terminatorChars_q[i] <= '0;
    end
    else if (wbReq && wb_we_i)
    begin
      if (wb_adr_i == arxf_pkg::A_RXBASE)
      begin
        if (wb_sel_i[0]) receiveStoreBase_q[7:0] <= wb_dat_i[7:0];
        if (wb_sel_i[1]) receiveStoreBase_q[15:8] <= wb_dat_i[15:8];
      end
      if (wb_adr_i == arxf_pkg::A_TXBASE)
      begin
        if (wb_sel_i[0]) transmitSourceBase_q[7:0] <= wb_dat_i[7:0];
        if (wb_sel_i[1]) transmitSourceBase_q[15:8] <= wb_dat_i[15:8];
      end
      // Reserved type bits 4 to 7 are stored but ignored
      if (wb_adr_i == arxf_pkg::A_TTYPE && wb_sel_i[0])
        termType_q <= wb_dat_i[7:0];
      // Counts above twelve clamp so the compare never runs off the array
      if (wb_adr_i == arxf_pkg::A_TCOUNT && wb_sel_i[0])
        terminatorCount_q <= (wb_dat_i[7:0] > 8'(arxf_pkg::TERM_MAX)) ?
          4'(arxf_pkg::TERM_MAX) : wb_dat_i[3:0];
      if (wb_adr_i == arxf_pkg::A_PKTLEN && wb_sel_i[0])
        packetLength_q <= (wb_dat_i[7:0] > 8'(arxf_pkg::PKT_MAX)) ?
          8'(arxf_pkg::PKT_MAX) : wb_dat_i[7:0];
      if (wb_adr_i == arxf_pkg::A_MSGTO)
      begin
        if (wb_sel_i[0]) msgTimeout_q[7:0] <= wb_dat_i[7:0];
        if (wb_sel_i[1]) msgTimeout_q[15:8] <= wb_dat_i[15:8];
      end
      if (wb_adr_i == arxf_pkg::A_GAPTO)
      begin
        if (wb_sel_i[0]) gapTimeout_q[7:0] <= wb_dat_i[7:0];
        if (wb_sel_i[1]) gapTimeout_q[15:8] <= wb_dat_i[15:8];
      end
      if (wb_adr_i >= arxf_pkg::A_TCHAR0 &&
          wb_adr_i < arxf_pkg::A_TCHAR_END && wb_sel_i[0])
        terminatorChars_q[wordIdx] <= wb_dat_i[7:0];
    end
  end

  // Read mux; status is only seen through this window
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      wb_dat_o <= '0;
    else if (wbReq && !wb_we_i)
    begin
      wb_dat_o <= '0;
      unique case (wb_adr_i)
        arxf_pkg::A_RXBASE: wb_dat_o <= {16'h0000, receiveStoreBase_q};
        arxf_pkg::A_TXBASE: wb_dat_o <= {16'h0000, transmitSourceBase_q};
        arxf_pkg::A_TTYPE: wb_dat_o <= {24'h000000, termType_q};
        arxf_pkg::A_TCOUNT: wb_dat_o <= {28'h0000000, terminatorCount_q};
        arxf_pkg::A_PKTLEN: wb_dat_o <= {24'h000000, packetLength_q};
        arxf_pkg::A_MSGTO: wb_dat_o <= {16'h0000, msgTimeout_q};
        arxf_pkg::A_GAPTO: wb_dat_o <= {16'h0000, gapTimeout_q};
        arxf_pkg::A_STATUS: wb_dat_o <= {msgCount_q[7:0], charCount_q[7:0],
          5'h00, state_q, 8'(fill_q)};
        default:
          if (wb_adr_i >= arxf_pkg::A_TCHAR0 &&
              wb_adr_i < arxf_pkg::A_TCHAR_END)
            wb_dat_o <= {24'h000000, terminatorChars_q[wordIdx]};
      endcase
    end
  end

  // Shared millisecond tick for both timers
  arxf_tick_gen #(
    .PERIOD(TICK_PERIOD)
  ) u_tick (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .tick(tick)
  );

  // Message timer armed by the first character of a block
  arxf_ms_timer #(
    .W(16)
  ) u_msg (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .tick(tick),
    .start(accept && fill_q == '0 && termType_q[arxf_pkg::TT_MSGTO]),
    .stop(endBlock),
    .limit(msgTimeout_q),
    .expired(msgExpired)
  );

  // Gap timer re-armed by every character
  arxf_ms_timer #(
    .W(16)
  ) u_gap (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .tick(tick),
    .start(accept && termType_q[arxf_pkg::TT_GAP]),
    .stop(endBlock),
    .limit(gapTimeout_q),
    .expired(gapExpired)
  );

  // Terminator match against the used part of the set
  always_comb
  begin
    isTerm = 1'b0;
    for (int i = 0; i < arxf_pkg::TERM_MAX; i++)
      if (4'(i) < terminatorCount_q && rxChar == terminatorChars_q[i])
        isTerm = 1'b1;
  end

  // Characters are taken only while collecting and receive is enabled
  // Full refuses rather than overwrites; the full close normally wins
  assign accept = rxValid && rxEnable && state_q != arxf_pkg::ST_SEND &&
    fill_q != FULL;
  assign rxDropped = rxValid && !accept;
  assign newFill = accept ? fill_q + 1'b1 : fill_q;

  // Any enabled condition can close the block
  // Closing takes newFill, so a character accepted on the closing edge
  // always leaves with its block rather than being lost
  always_comb
  begin
    endBlock = 1'b0;
    if (state_q != arxf_pkg::ST_SEND)
    begin
      if (accept && streamMode)
        endBlock = 1'b1;
      if (accept && termType_q[arxf_pkg::TT_CHAR] && isTerm)
        endBlock = 1'b1;
      if (msgExpired && fill_q != '0)
        endBlock = 1'b1;
      if (gapExpired && fill_q != '0)
        endBlock = 1'b1;
      if (termType_q[arxf_pkg::TT_LEN] && packetLength_q != '0 &&
          newFill == PW'(packetLength_q) && accept)
        endBlock = 1'b1;
      if (accept && newFill == FULL)
        endBlock = 1'b1;
    end
  end

  assign drainBeat = dbValid && dbReady;
  assign nextRd = rdPtr_q + 1'b1;

  // Collect, then drain the closed block to the database port
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      state_q <= arxf_pkg::ST_LISTEN;
      fill_q <= '0;
      sendLen_q <= '0;
      rdPtr_q <= '0;
    end
    else
    begin
      unique case (state_q)
        arxf_pkg::ST_LISTEN, arxf_pkg::ST_RECV:
        begin
          if (endBlock)
          begin
            state_q <= arxf_pkg::ST_SEND;
            sendLen_q <= newFill;
            rdPtr_q <= '0;
          end
          else if (accept)
            state_q <= arxf_pkg::ST_RECV;
          fill_q <= newFill;
        end
        arxf_pkg::ST_SEND:
          if (drainBeat)
          begin
            if (rdPtr_q == sendLen_q - 1'b1)
            begin
              state_q <= arxf_pkg::ST_LISTEN;
              fill_q <= '0;
            end
            rdPtr_q <= rdPtr_q + 1'b1;
          end
        default:
          state_q <= arxf_pkg::ST_LISTEN;
      endcase
    end
  end

  // Buffer write port
  always_ff @(posedge ref_clk)
  begin
    if (accept)
      mem_q[fill_q[$clog2(DEPTH)-1:0]] <= rxChar;
  end

  // Drain handshake outputs follow the state directly
  assign dbValid = (state_q == arxf_pkg::ST_SEND);
  assign dbLast = dbValid && (rdPtr_q == sendLen_q - 1'b1);
  assign dbData = dbData_q;

  // Drain data leaves a flip-flop; a block closed by its first character
  // still has that byte on rxChar, so it bypasses the array
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      dbData_q <= '0;
    else if (endBlock)
      dbData_q <= (fill_q == '0) ? rxChar : mem_q[0];
    else if (drainBeat && !dbLast)
      dbData_q <= mem_q[nextRd[$clog2(DEPTH)-1:0]];
  end

  // Statistics counters
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      charCount_q <= '0;
      msgCount_q <= '0;
    end
    else
    begin
      if (accept)
        charCount_q <= charCount_q + 1'b1;
      if (drainBeat && dbLast)
        msgCount_q <= msgCount_q + 1'b1;
    end
  end
endmodule

// [testbench/arxf_serial_dev.sv]
// Purpose: Far-end ASCII device sending characters into the framer.
// Assumes: One character per one-cycle strobe on ref_clk.
// Notes: Idle data shows the inverse of the last character.
module arxf_serial_dev (
  input wire logic ref_clk,
  output logic rxValid,
  output logic [7:0] rxChar
);
  timeunit 1ns;
  timeprecision 1ps;

  // Quiet line at time zero
  initial
  begin
    rxValid = 1'h0;
    rxChar = 8'h00;
  end

  // Stale data is inverted so a late sample cannot pass by luck
  task automatic send(input logic [7:0] c);
    @(posedge ref_clk);
    rxValid <= 1'h1;
    rxChar <= c;
    @(posedge ref_clk);
    rxValid <= 1'h0;
    rxChar <= ~c;
  endtask
endmodule

// [testbench/arxf_framer_sva.sv]
// Purpose: Port checker for the receive framer.
// Assumes: One clock, synchronous active-high reset.
// Notes: Bound to every framer instance.
module arxf_framer_sva #(
  parameter int unsigned DEPTH = 255,
  parameter int unsigned TICK_PERIOD = 10
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic rxValid,
  input wire logic rxDropped,
  input wire logic dbValid,
  input wire logic [7:0] dbData,
  input wire logic dbLast,
  input wire logic [15:0] dbBase,
  input wire logic dbReady,
  input wire logic rxEnable,
  input wire logic txEnable,
  input wire logic [15:0] transmitSourceBase
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  // Drain steps
  sequence s_stall;
    dbValid && !dbReady;
  endsequence
  sequence s_last_taken;
    dbValid && dbLast && dbReady;
  endsequence

  a_ack_answer: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_rx_gate: assert property (
    rxEnable == (dbBase != 16'hFFFF))
    else $error("receive enable disagrees with base");
  a_tx_gate: assert property (
    txEnable == (transmitSourceBase != 16'hFFFF))
    else $error("transmit enable disagrees with base");
  a_rx_refuse: assert property (rxValid && !rxEnable |-> rxDropped)
    else $error("character kept while receive off");
  a_send_refuse: assert property (rxValid && dbValid |-> rxDropped)
    else $error("character kept during drain");
  a_rx_keep: assert property (
    rxValid && rxEnable && !dbValid |-> !rxDropped)
    else $error("character lost while listening");
  a_stall_hold: assert property (
    s_stall |=> dbValid && $stable(dbData) && $stable(dbLast))
    else $error("drain moved while stalled");
  a_last_ends: assert property (s_last_taken |=> !dbValid)
    else $error("drain continued past last byte");
endmodule

bind arxf_framer arxf_framer_sva #(.DEPTH(DEPTH), .TICK_PERIOD(TICK_PERIOD))
  u_sva (.ref_clk(ref_clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .rxValid(rxValid),
  .rxDropped(rxDropped), .dbValid(dbValid), .dbData(dbData),
  .dbLast(dbLast), .dbBase(dbBase), .dbReady(dbReady),
  .rxEnable(rxEnable), .txEnable(txEnable),
  .transmitSourceBase(transmitSourceBase));

// [testbench/test_ascii_rx_message_framer.sv]
// Purpose: Self-checking bench for the receive framer.
// Assumes: 1 ms is 10 cycles, buffer depth 8 to reach the full case.
// Notes: Drain side stalls every other cycle.
module test_ascii_rx_message_framer;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, sys_rst, cyc, stb, we, ack, rxValid, rxDropped;
  logic dbValid, dbLast, dbReady, rxEnable, txEnable;
  logic [7:0] adr, rxChar, dbData;
  logic [31:0] wdat, rdat;
  logic [15:0] dbBase, txBase;
  logic [8:0] expQ[$];
  logic [8:0] expByte;
  int errTotal, nTests, cycles, drops;

  arxf_framer #(.DEPTH(8), .TICK_PERIOD(10)) dut (.ref_clk(ref_clk),
    .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .rxValid(rxValid), .rxChar(rxChar),
    .rxDropped(rxDropped), .dbValid(dbValid), .dbData(dbData),
    .dbLast(dbLast), .dbBase(dbBase), .dbReady(dbReady),
    .rxEnable(rxEnable), .txEnable(txEnable), .transmitSourceBase(txBase));
  arxf_serial_dev dev (.ref_clk(ref_clk), .rxValid(rxValid), .rxChar(rxChar));

  // Free-running clock
  initial
  begin
    ref_clk = 1'h0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    nTests++;
    if (seen !== want)
    begin
      errTotal++;
      $display("BAD %0t seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic print_verdict();
    $display("mismatches %0d of %0d checks", errTotal, nTests);
    if (errTotal == 0 && nTests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Classic cycle: hold until ack is sampled, then release
  task automatic wb(input logic [7:0] a, input logic w,
                    input logic [31:0] d, output logic [31:0] q);
    @(posedge ref_clk);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge ref_clk); while (ack !== 1'h1);
    q = rdat;
    cyc <= 1'h0;
    stb <= 1'h0;
    we <= 1'h0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(a, 1'h1, d, q);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] want);
    logic [31:0] q;
    wb(a, 1'h0, 32'h00000000, q);
    check(q, want);
  endtask

  // A block is queued with its last flag on the final byte
  task automatic exp_blk(input string s);
    for (int i = 0; i < s.len(); i++)
      expQ.push_back({i == s.len() - 1, s[i]});
  endtask

  // Characters sent during a drain would be dropped, so wait it out
  task automatic send_str(input string s);
    for (int i = 0; i < s.len(); i++)
    begin
      @(posedge ref_clk);
      while (dbValid !== 1'h0) @(posedge ref_clk);
      dev.send(s[i]);
    end
  endtask

  task automatic drained();
    for (int k = 0; k < 400 && (expQ.size() != 0 || dbValid !== 1'h0); k++)
      @(posedge ref_clk);
    check(32'(expQ.size()), 32'h00000000);
  endtask

  // Drain side compares every byte handed over
  always @(posedge ref_clk)
  begin
    dbReady <= ~dbReady;
    if (dbValid === 1'h1 && dbReady === 1'h1)
    begin
      expByte = (expQ.size() != 0) ? expQ.pop_front() : 9'h1FF;
      check(32'({dbLast, dbData}), 32'(expByte));
    end
  end

  // Hang guard and refused-character count
  always @(posedge ref_clk)
  begin
    cycles++;
    if (rxValid === 1'h1 && rxDropped === 1'h1)
      drops++;
    if (cycles == 30000)
    begin
      errTotal++;
      print_verdict();
    end
  end

  initial
  begin
    {cyc, stb, we, dbReady} = 4'h0;
    adr = 8'h00;
    wdat = 32'h00000000;
    sys_rst = 1'h1;
    repeat (16) @(posedge ref_clk);
    sys_rst <= 1'h0;
    rd_chk(arxf_pkg::A_RXBASE, 32'h0000FFFF);
    rd_chk(arxf_pkg::A_TTYPE, 32'h00000000);
    rd_chk(arxf_pkg::A_STATUS, 32'h00000100);
    rd_chk(8'h30, 32'h00000000);
    wr(arxf_pkg::A_TXBASE, 32'h00000100);
    check(32'({txEnable, rxEnable}), 32'h00000002);
    send_str("Z");
    wr(arxf_pkg::A_RXBASE, 32'h00000200);
    check(drops, 32'h00000001);
    wr(arxf_pkg::A_TXBASE, 32'h0000FFFF);
    check(32'({txEnable, rxEnable, dbBase}), 32'h00010200);
    wr(arxf_pkg::A_TXBASE, 32'h00000100);
    check(32'({txEnable, rxEnable, txBase}), 32'h00030100);
    exp_blk("A");
    exp_blk("B");
    send_str("AB");
    drained();
    wr(arxf_pkg::A_TCOUNT, 32'h0000000F);
    rd_chk(arxf_pkg::A_TCOUNT, 32'h0000000C);
    wr(arxf_pkg::A_PKTLEN, 32'h000000FF);
    rd_chk(arxf_pkg::A_PKTLEN, 32'h000000C8);
    wr(arxf_pkg::A_TCOUNT, 32'h00000001);
    wr(arxf_pkg::A_TCHAR0, 32'h0000000D);
    wr(arxf_pkg::A_TTYPE, 32'h00000001);
    exp_blk("ABC\015");
    send_str("ABC\015DE");
    drained();
    exp_blk("DE\015");
    send_str("\015");
    drained();
    wr(arxf_pkg::A_PKTLEN, 32'h00000004);
    wr(arxf_pkg::A_TTYPE, 32'h00000008);
    exp_blk("ABCD");
    exp_blk("EFGH");
    send_str("ABCDEFGHIJ");
    drained();
    wr(arxf_pkg::A_PKTLEN, 32'h00000003);
    wr(arxf_pkg::A_TTYPE, 32'h00000009);
    exp_blk("IJK");
    exp_blk("L\015");
    send_str("KL\015");
    drained();
    wr(arxf_pkg::A_MSGTO, 32'h00000003);
    wr(arxf_pkg::A_TTYPE, 32'h00000002);
    exp_blk("MNO");
    send_str("MNO");
    drained();
    wr(arxf_pkg::A_GAPTO, 32'h00000002);
    wr(arxf_pkg::A_TTYPE, 32'h00000004);
    exp_blk("PQ");
    send_str("PQ");
    drained();
    wr(arxf_pkg::A_PKTLEN, 32'h00000000);
    wr(arxf_pkg::A_TTYPE, 32'h00000008);
    exp_blk("STUVWXYZ");
    send_str("STUVWXYZ");
    // A character landing during the drain must be refused
    dev.send(8'h21);
    drained();
    check(drops, 32'h00000002);
    // Counts: 35 characters kept, 11 blocks handed over, back to listening
    rd_chk(arxf_pkg::A_STATUS, 32'h0B230100);
    print_verdict();
  end
endmodule
